/* File: src/serial_port_consts.svh */
// Contract
// - Asynchronous full-duplex serial port offering variable-rate 8-bit and 9-bit modes 1, 3.
// - A finished receive byte is buffered while the next byte shifts in.
// - Writes to the shared data location go to the transmit register; a write while busy is dropped.
// - Reads of the shared data location return the receive buffer, never transmit data.
// - With interrupt enabled, setting either done flag requests an interrupt.
// - Done flags stay set through the interrupt; software clears them explicitly.
// - Transmit bit timing comes from overflows of the 8-bit auto-reload timer low byte.
// - A hidden receive timer copy counts when the timer runs, same reload byte.
// - Transmit and receive timer overflows are each halved to form bit rates.
// - A detected start condition forces a reload of the hidden receive timer.
// - Overflow rate is timer clock over 256 minus reload; bit rate is half.
// - Timer clock selects core clock, core clock over 4, 12, 48, oscillator/8, pin.
// - Timer may run from external oscillator while core clock comes from elsewhere.
// - Frame mode select bit: 0 gives 8-bit frames, 1 gives 9-bit frames.
// - An 8-bit frame is start bit, eight data bits LSB first, stop bit.
// - Transmit done flag sets after the last data bit, at stop-bit start.
// - Receive load and flag set need flag clear and, with multidrop check, ninth bit one.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// =============================================
// Register offsets
`define SP_CTRL_OFS   8'h00
`define SP_DATA_OFS   8'h04
`define SP_TMR_OFS    8'h08
`define SP_RELOAD_OFS 8'h0c
`define SP_STAT_OFS   8'h10
`define SP_MASK_OFS   8'h14

// =============================================
// Field positions
`define CTRL_MODE_BIT 7
`define CTRL_MCE_BIT  5
`define CTRL_REN_BIT  4
`define CTRL_TB8_BIT  3
`define STAT_RX_BIT   0
`define STAT_TX_BIT   1

// =============================================
// Reset values and counts
`define BYTE_RST     8'h00
`define SYNC_RST     3'h7
`define TIMER_TOP    8'hff
`define PRESC_DIV4   4
`define PRESC_DIV12  12
`define PRESC_DIV48  48
`define OSC_DIV_TOP  3'h7
`define FRAME8_BITS  4'ha
`define FRAME9_BITS  4'hb
`define DATA8_BITS   4'h8
`define DATA9_BITS   4'h9

`endif

/* File: src/serial_port_pkg.sv */
package serial_port_pkg;

	// =============================================
	// State machines
	typedef enum logic [1:0] {
		TX_IDLE = 2'h1,
		TX_SEND = 2'h2
	} tx_state_type;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rx_state_type;

	// =============================================
	// Timer clock sources
	typedef enum logic [2:0] {
		SRC_CORE   = 3'h0,
		SRC_DIV4   = 3'h1,
		SRC_DIV12  = 3'h2,
		SRC_DIV48  = 3'h3,
		SRC_EXTOSC = 3'h4,
		SRC_PIN    = 3'h5
	} clk_src_type;

	// =============================================
	// Register layouts
	typedef struct packed {
		logic frame_mode_select;
		logic multidrop_check_enable;
		logic receive_enable_bit;
		logic transmit_ninth_bit;
	} serial_ctrl_type;

	typedef struct packed {
		logic        run;
		clk_src_type src;
	} timer_ctrl_type;

endpackage

/* File: src/serial_port.sv */
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module serial_port
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic [31:0]      prdata_o,
	// Serial lines
	input  wire logic        rxd_i,
	output logic             txd_o,
	// Baud timer clock inputs
	input  wire logic        ext_osc_i,
	input  wire logic        timer_external_input_i,
	// Interrupt
	output logic             irq_o
);

	// =============================================
	// Declarations
	serial_port_pkg::serial_ctrl_type ctrl_reg;
	serial_port_pkg::timer_ctrl_type  tmr_reg;
	serial_port_pkg::tx_state_type    tx_state_reg;
	serial_port_pkg::rx_state_type    rx_state_reg;
	logic [7:0]  timer_reload_byte_reg;
	logic [7:0]  timer_low_count_reg;
	logic [7:0]  rx_timer_reg;
	logic [1:0]  mask_reg;
	logic        transmit_done_flag_reg;
	logic        receive_done_flag_reg;
	logic        received_ninth_bit_reg;
	logic [7:0]  rx_buf_reg;
	logic        pready_reg;
	logic        slverr_reg;
	logic [31:0] prdata_reg;
	logic [31:0] rdata_next;
	logic        addr_ok;
	logic        acc;
	logic        wr_en;
	logic        tx_clr;
	logic        rx_clr;
	logic [2:0]  sync1_reg;
	logic [2:0]  sync2_reg;
	logic [2:0]  sync3_reg;
	logic        rx_now;
	logic [2:0]  div_tick;
	logic [2:0]  osc_cnt_reg;
	logic        osc_tick;
	logic        pin_tick;
	logic        tmr_tick;
	logic        cnt_en;
	logic        tx_ovf;
	logic        rx_ovf;
	logic        tx_half_reg;
	logic        rx_half_reg;
	logic        tx_bit_tick;
	logic        rx_samp;
	logic        start_det;
	logic [10:0] tx_shift_reg;
	logic [3:0]  tx_cnt_reg;
	logic        txd_reg;
	logic        tx_load;
	logic        tx_done_set;
	logic [8:0]  rx_shift_reg;
	logic [3:0]  rx_cnt_reg;
	logic [7:0]  rx_byte;
	logic        rx_ninth;
	logic        rx_load;

	// =============================================
	// APB slave: one wait state, data from flops
	assign acc       = psel_i & penable_i;
	assign wr_en     = acc & pready_reg & pwrite_i & addr_ok;
	assign pready_o  = pready_reg;
	assign pslverr_o = pready_reg & slverr_reg;
	assign prdata_o  = prdata_reg;

	// Read mux and address decode
	always_comb
	begin
		addr_ok    = 1'b1;
		rdata_next = 32'h0000_0000;
		case (paddr_i)
			`SP_CTRL_OFS:   rdata_next[7:0] = {ctrl_reg.frame_mode_select, 1'b1,
				ctrl_reg.multidrop_check_enable, ctrl_reg.receive_enable_bit,
				ctrl_reg.transmit_ninth_bit, received_ninth_bit_reg,
				transmit_done_flag_reg, receive_done_flag_reg};
			`SP_DATA_OFS:   rdata_next[7:0] = rx_buf_reg;
			`SP_TMR_OFS:    rdata_next[3:0] = tmr_reg;
			`SP_RELOAD_OFS: rdata_next[7:0] = timer_reload_byte_reg;
			`SP_STAT_OFS:   rdata_next[1:0] = {transmit_done_flag_reg, receive_done_flag_reg};
			`SP_MASK_OFS:   rdata_next[1:0] = mask_reg;
			default:        addr_ok = 1'b0;
		endcase
	end

	// Answer one cycle into the access phase
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			pready_reg <= 1'b0;
			slverr_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
		end
		else
		begin
			pready_reg <= acc & ~pready_reg;
			if (acc & ~pready_reg)
			begin
				slverr_reg <= ~addr_ok;
				prdata_reg <= pwrite_i ? 32'h0000_0000 : rdata_next;
			end
		end
	end

	// Software configuration registers
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			ctrl_reg              <= '0;
			tmr_reg               <= '0;
			timer_reload_byte_reg <= `BYTE_RST;
			mask_reg              <= 2'h0;
		end
		else if (wr_en)
		begin
			case (paddr_i)
				`SP_CTRL_OFS:   ctrl_reg <= {pwdata_i[`CTRL_MODE_BIT], pwdata_i[`CTRL_MCE_BIT],
					pwdata_i[`CTRL_REN_BIT], pwdata_i[`CTRL_TB8_BIT]};
				`SP_TMR_OFS:    tmr_reg <= serial_port_pkg::timer_ctrl_type'(pwdata_i[3:0]);
				`SP_RELOAD_OFS: timer_reload_byte_reg <= pwdata_i[7:0];
				`SP_MASK_OFS:   mask_reg <= pwdata_i[1:0];
				default:        mask_reg <= mask_reg;
			endcase
		end
	end

	// =============================================
	// Done flags and interrupt; a set wins over a clear
	assign tx_clr = wr_en & (paddr_i == `SP_STAT_OFS) & pwdata_i[`STAT_TX_BIT];
	assign rx_clr = wr_en & (paddr_i == `SP_STAT_OFS) & pwdata_i[`STAT_RX_BIT];

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			transmit_done_flag_reg <= 1'b0;
			receive_done_flag_reg  <= 1'b0;
		end
		else
		begin
			transmit_done_flag_reg <= tx_done_set | (transmit_done_flag_reg & ~tx_clr);
			receive_done_flag_reg  <= rx_load | (receive_done_flag_reg & ~rx_clr);
		end
	end

	// Level request while any unmasked flag stands
	assign irq_o = |({transmit_done_flag_reg, receive_done_flag_reg} & mask_reg);

	// =============================================
	// Pin synchronisers: receive line, oscillator, timer pin
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync1_reg <= `SYNC_RST;
			sync2_reg <= `SYNC_RST;
			sync3_reg <= `SYNC_RST;
		end
		else
		begin
			sync1_reg <= {timer_external_input_i, ext_osc_i, rxd_i};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign rx_now   = sync2_reg[0];
	assign pin_tick = sync3_reg[2] & ~sync2_reg[2];

	// =============================================
	// Core clock prescalers for divide by 4, 12 and 48
	for (genvar g = 0; g < 3; g++)
	begin : g_presc
		localparam logic [5:0] TOP = 6'((g == 0) ? `PRESC_DIV4 - 1 :
			(g == 1) ? `PRESC_DIV12 - 1 : `PRESC_DIV48 - 1);
		logic [5:0] cnt_reg;
		always_ff @(posedge clk_i or negedge rstn_i)
		begin
			if (!rstn_i)
				cnt_reg <= 6'h00;
			else
				cnt_reg <= (cnt_reg == TOP) ? 6'h00 : cnt_reg + 6'h01;
		end
		assign div_tick[g] = (cnt_reg == TOP);
	end

	// Oscillator divided by 8; the core clock may come from another source
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			osc_cnt_reg <= 3'h0;
		else if (sync2_reg[1] & ~sync3_reg[1])
			osc_cnt_reg <= osc_cnt_reg + 3'h1;
	end

	assign osc_tick = sync2_reg[1] & ~sync3_reg[1] & (osc_cnt_reg == `OSC_DIV_TOP);

	// Timer clock source select
	always_comb
	begin
		tmr_tick = 1'b0;
		case (tmr_reg.src)
			serial_port_pkg::SRC_CORE:   tmr_tick = 1'b1;
			serial_port_pkg::SRC_DIV4:   tmr_tick = div_tick[0];
			serial_port_pkg::SRC_DIV12:  tmr_tick = div_tick[1];
			serial_port_pkg::SRC_DIV48:  tmr_tick = div_tick[2];
			serial_port_pkg::SRC_EXTOSC: tmr_tick = osc_tick;
			serial_port_pkg::SRC_PIN:    tmr_tick = pin_tick;
			default:                     tmr_tick = 1'b0;
		endcase
	end

	// =============================================
	// Auto-reload timer and its hidden receive copy
	assign cnt_en    = tmr_reg.run & tmr_tick;
	assign tx_ovf    = cnt_en & (timer_low_count_reg == `TIMER_TOP);
	assign rx_ovf    = cnt_en & (rx_timer_reg == `TIMER_TOP) & ~start_det;
	assign start_det = (rx_state_reg == serial_port_pkg::RX_IDLE) &
		ctrl_reg.receive_enable_bit & sync3_reg[0] & ~rx_now;

	// Reload on overflow gives 256 minus reload counts per overflow
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			timer_low_count_reg <= `BYTE_RST;
			rx_timer_reg        <= `BYTE_RST;
		end
		else
		begin
			if (cnt_en)
				timer_low_count_reg <= tx_ovf ? timer_reload_byte_reg
					: timer_low_count_reg + 8'h01;
			if (start_det)
				rx_timer_reg <= timer_reload_byte_reg;
			else if (cnt_en)
				rx_timer_reg <= (rx_timer_reg == `TIMER_TOP) ? timer_reload_byte_reg
					: rx_timer_reg + 8'h01;
		end
	end

	// Halving; receive phase restarts at a start so sampling lands mid-bit
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_half_reg <= 1'b0;
			rx_half_reg <= 1'b0;
		end
		else
		begin
			if (tx_ovf)
				tx_half_reg <= ~tx_half_reg;
			if (start_det)
				rx_half_reg <= 1'b1;
			else if (rx_ovf)
				rx_half_reg <= ~rx_half_reg;
		end
	end

	assign tx_bit_tick = tx_ovf & tx_half_reg;
	assign rx_samp     = rx_ovf & rx_half_reg;

	// =============================================
	// Transmitter; a write while busy is dropped
	assign tx_load     = wr_en & (paddr_i == `SP_DATA_OFS) &
		(tx_state_reg == serial_port_pkg::TX_IDLE);
	assign tx_done_set = (tx_state_reg == serial_port_pkg::TX_SEND) & tx_bit_tick &
		(tx_cnt_reg == 4'h1);
	assign txd_o       = txd_reg;

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			tx_state_reg <= serial_port_pkg::TX_IDLE;
			tx_shift_reg <= 11'h7ff;
			tx_cnt_reg   <= 4'h0;
			txd_reg      <= 1'b1;
		end
		else
		begin
			case (tx_state_reg)
				serial_port_pkg::TX_IDLE:
				begin
					if (tx_load)
					begin
						tx_state_reg <= serial_port_pkg::TX_SEND;
						tx_shift_reg <= {1'b1, ctrl_reg.frame_mode_select ?
							ctrl_reg.transmit_ninth_bit : 1'b1, pwdata_i[7:0], 1'b0};
						tx_cnt_reg   <= ctrl_reg.frame_mode_select ?
							`FRAME9_BITS : `FRAME8_BITS;
					end
				end
				serial_port_pkg::TX_SEND:
				begin
					if (tx_bit_tick)
					begin
						if (tx_cnt_reg == 4'h0)
							tx_state_reg <= serial_port_pkg::TX_IDLE;
						else
						begin
							txd_reg      <= tx_shift_reg[0];
							tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
							tx_cnt_reg   <= tx_cnt_reg - 4'h1;
						end
					end
				end
				default: tx_state_reg <= serial_port_pkg::TX_IDLE;
			endcase
		end
	end

	// =============================================
	// Receiver with a holding buffer apart from the shifter
	assign rx_byte  = ctrl_reg.frame_mode_select ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
	assign rx_ninth = ctrl_reg.frame_mode_select ? rx_shift_reg[8] : rx_now;
	assign rx_load  = (rx_state_reg == serial_port_pkg::RX_STOP) & rx_samp &
		~receive_done_flag_reg & (~ctrl_reg.multidrop_check_enable | rx_ninth);

	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_state_reg <= serial_port_pkg::RX_IDLE;
			rx_shift_reg <= 9'h000;
			rx_cnt_reg   <= 4'h0;
		end
		else
		begin
			case (rx_state_reg)
				serial_port_pkg::RX_IDLE:
					if (start_det)
						rx_state_reg <= serial_port_pkg::RX_START;
				serial_port_pkg::RX_START:
				begin
					if (rx_samp)
					begin
						// A high line at mid start bit was a glitch
						rx_state_reg <= rx_now ? serial_port_pkg::RX_IDLE
							: serial_port_pkg::RX_DATA;
						rx_cnt_reg   <= ctrl_reg.frame_mode_select ?
							`DATA9_BITS : `DATA8_BITS;
					end
				end
				serial_port_pkg::RX_DATA:
				begin
					if (rx_samp)
					begin
						rx_shift_reg <= {rx_now, rx_shift_reg[8:1]};
						rx_cnt_reg   <= rx_cnt_reg - 4'h1;
						if (rx_cnt_reg == 4'h1)
							rx_state_reg <= serial_port_pkg::RX_STOP;
					end
				end
				serial_port_pkg::RX_STOP:
					if (rx_samp)
						rx_state_reg <= serial_port_pkg::RX_IDLE;
				default: rx_state_reg <= serial_port_pkg::RX_IDLE;
			endcase
		end
	end

	// Holding buffer; overrun keeps the older byte
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			rx_buf_reg             <= `BYTE_RST;
			received_ninth_bit_reg <= 1'b0;
		end
		else if (rx_load)
		begin
			rx_buf_reg             <= rx_byte;
			received_ninth_bit_reg <= rx_ninth;
		end
	end

	// =============================================
	// Checks
	logic [1:0] ovf_seen_reg;

	// Overflows since the last transmit bit tick
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			ovf_seen_reg <= 2'h0;
		else if (tx_bit_tick)
			ovf_seen_reg <= 2'h0;
		else if (tx_ovf)
			ovf_seen_reg <= ovf_seen_reg + 2'h1;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rstn_i);

	chk_read_rx_buffer: assert property (
		acc && !pready_reg && !pwrite_i && paddr_i == `SP_DATA_OFS
		|=> prdata_o == {24'h00_0000, $past(rx_buf_reg)})
		else $error("data read did not return receive buffer");
	chk_write_tx_load: assert property (
		tx_load |=> tx_state_reg == serial_port_pkg::TX_SEND
		&& tx_shift_reg[8:1] == $past(pwdata_i[7:0])
		&& ($stable(rx_buf_reg) || $past(rx_load))) // Receive may land alongside
		else $error("data write did not reach transmitter only");
	chk_irq_on_done: assert property (
		tx_done_set && mask_reg[`STAT_TX_BIT] |=> irq_o)
		else $error("transmit done did not raise interrupt");
	chk_flag_sticky: assert property (
		transmit_done_flag_reg && !tx_clr |=> transmit_done_flag_reg)
		else $error("transmit done flag dropped without clear");
	chk_bit_halving: assert property (
		tx_bit_tick |-> ovf_seen_reg == 2'h1)
		else $error("bit tick not every second overflow");
	chk_rx_reload: assert property (
		start_det |=> rx_timer_reg == $past(timer_reload_byte_reg))
		else $error("start did not reload receive timer");
	chk_timer_reload: assert property (
		tx_ovf |=> timer_low_count_reg == $past(timer_reload_byte_reg))
		else $error("timer overflow did not reload");
	chk_done_at_stop: assert property (
		tx_done_set |=> txd_o && transmit_done_flag_reg ##1 txd_o)
		else $error("transmit done not at stop bit");
	chk_rx_accept: assert property (
		rx_load |-> !receive_done_flag_reg ##1 receive_done_flag_reg
		&& rx_buf_reg == $past(rx_byte))
		else $error("received byte not loaded with flag");

endmodule // serial_port

/* File: testbench/remote_transceiver.sv */
`timescale 1ns/1ps

module remote_transceiver
(
	// Clock
	input  wire logic clk_i,
	// Serial lines, named from the device side
	input  wire logic txd_i,
	output logic      rxd_o
);
	int         bit_clks = 16;
	int         rx_bits  = 8;
	int         frames   = 0;
	logic [8:0] got;
	logic       got_stop;

	initial rxd_o = 1'b1;

	// =============================================
	// Sender: start, data LSB first, stop; line driven high when idle
	task automatic send(input logic [8:0] v, input int nb, input logic stop);
		@(posedge clk_i);
		rxd_o <= 1'b0;
		repeat (bit_clks) @(posedge clk_i);
		for (int i = 0; i < nb; i++)
		begin
			rxd_o <= v[i];
			repeat (bit_clks) @(posedge clk_i);
		end
		rxd_o <= stop;
		repeat (bit_clks) @(posedge clk_i);
		rxd_o <= 1'b1;
	endtask

	// =============================================
	// Receiver: mid-bit sampling, so a wrong bit rate corrupts the byte
	initial
	forever
	begin
		@(negedge txd_i);
		got = 9'h000;
		repeat (bit_clks / 2) @(posedge clk_i);
		for (int i = 0; i < rx_bits; i++)
		begin
			repeat (bit_clks) @(posedge clk_i);
			got[i] = txd_i;
		end
		repeat (bit_clks) @(posedge clk_i);
		got_stop = txd_i;
		frames++;
	end
endmodule // remote_transceiver

/* File: testbench/async_serial_port_timer_baud_tb.sv */
`timescale 1ns/1ps
`include "serial_port_consts.svh"

module async_serial_port_timer_baud_tb;
	logic                            clk_i;
	logic                            rstn_i;
	logic                            psel_i;
	logic                            penable_i;
	logic                            pwrite_i;
	logic [7:0]                      paddr_i;
	logic [31:0]                     pwdata_i;
	logic                            pready_o;
	logic                            pslverr_o;
	logic [31:0]                     prdata_o;
	logic                            rxd_i;
	logic                            txd_o;
	logic                            irq_o;
	logic [1:0]                      osc_cnt_reg = 2'h0;
	logic [31:0]                     rdat;
	logic                            rerr;
	int                              errors;
	int                              n_checks;
	int                              n0;
	serial_port_pkg::timer_ctrl_type tmr;
	serial_port_pkg::clk_src_type    srcs [5];
	int                              mult [5];

	serial_port serial_port_i
	(
		.clk_i                  (clk_i),
		.rstn_i                 (rstn_i),
		.psel_i                 (psel_i),
		.penable_i              (penable_i),
		.pwrite_i               (pwrite_i),
		.paddr_i                (paddr_i),
		.pwdata_i               (pwdata_i),
		.pready_o               (pready_o),
		.pslverr_o              (pslverr_o),
		.prdata_o               (prdata_o),
		.rxd_i                  (rxd_i),
		.txd_o                  (txd_o),
		.ext_osc_i              (osc_cnt_reg[1]),
		.timer_external_input_i (osc_cnt_reg[1]),
		.irq_o                  (irq_o)
	);

	remote_transceiver remote_transceiver_i
	(
		.clk_i (clk_i),
		.txd_i (txd_o),
		.rxd_o (rxd_i)
	);

	// =============================================
	// Clock, 5 ns period
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// Square wave for oscillator and pin sources, four clocks a period
	always @(posedge clk_i)
		osc_cnt_reg <= osc_cnt_reg + 2'h1;

	// =============================================
	// Helpers
	task automatic report_and_stop();
		if (errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	// APB transfer; held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		psel_i    <= 1'b1;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		penable_i <= 1'b0;
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Sampled at the rising edge; release only after ready is seen
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (pready_o !== 1'b1 && k < 50);
		rdat = prdata_o;
		rerr = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		if (k >= 50)
			chk("apb_ready", 32'h0000_0001, 32'h0000_0000);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rdat);
	endtask

	// Bounded waits; the frame wait also lets the stop bit run out
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq_o !== 1'b1 && k < 30000)
		begin
			@(negedge clk_i);
			k++;
		end
		chk("irq_rise", 32'h0000_0001, 32'(irq_o));
	endtask

	task automatic wait_frame();
		int k;
		k = 0;
		while (remote_transceiver_i.frames == n0 && k < 30000)
		begin
			@(negedge clk_i);
			k++;
		end
		chk("frame_seen", 32'h0000_0001, 32'(remote_transceiver_i.frames != n0));
		repeat (remote_transceiver_i.bit_clks) @(posedge clk_i);
	endtask

	task automatic tx_frame(input logic [8:0] e, input string nm);
		n0 = remote_transceiver_i.frames;
		wr(`SP_DATA_OFS, 32'(e[7:0]));
		wait_frame();
		chk(nm, 32'(e), 32'(remote_transceiver_i.got));
		chk("tx_stop", 32'h0000_0001, 32'(remote_transceiver_i.got_stop));
	endtask

	// =============================================
	// Watchdog, well beyond the expected run
	initial
	begin
		#400000;
		chk("watchdog", 32'h0000_0000, 32'h0000_0001);
		report_and_stop();
	end

	// =============================================
	// Main sequence
	initial
	begin
		errors = 0;
		n_checks = 0;
		rstn_i = 1'b0;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		srcs = '{serial_port_pkg::SRC_DIV4, serial_port_pkg::SRC_DIV12,
			serial_port_pkg::SRC_DIV48, serial_port_pkg::SRC_EXTOSC, serial_port_pkg::SRC_PIN};
		mult = '{4, 12, 48, 32, 4};
		repeat (2) @(posedge clk_i);
		rstn_i <= 1'b1;
		chk("txd_idle", 32'h0000_0001, 32'(txd_o));
		chk("irq_reset", 32'h0000_0000, 32'(irq_o));
		rd(`SP_CTRL_OFS, 32'h0000_0040, "ctrl_reset");
		rd(`SP_DATA_OFS, 32'h0000_0000, "data_reset");
		rd(`SP_STAT_OFS, 32'h0000_0000, "status_reset");
		rd(`SP_RELOAD_OFS, 32'h0000_0000, "reload_reset");
		apb(1'b0, 8'h18, 32'h0000_0000);
		chk("unmapped_err", 32'h0000_0001, 32'(rerr));
		chk("unmapped_data", 32'h0000_0000, rdat);
		// Reload 0xF8: overflow every 8 ticks, 16 clocks a bit on the core clock
		wr(`SP_RELOAD_OFS, 32'h0000_00f8);
		tmr.run = 1'b1;
		tmr.src = serial_port_pkg::SRC_CORE;
		wr(`SP_TMR_OFS, {28'h000_0000, tmr});
		wr(`SP_MASK_OFS, 32'h0000_0002);
		wr(`SP_CTRL_OFS, 32'h0000_0010);
		// Done flag must rise at the start of the stop bit, not at frame end
		n0 = remote_transceiver_i.frames;
		wr(`SP_DATA_OFS, 32'h0000_0035);
		wait_irq();
		chk("txd_at_flag", 32'h0000_0001, 32'(txd_o));
		chk("flag_mid_frame", 32'(n0), 32'(remote_transceiver_i.frames));
		wait_frame();
		chk("tx_byte", 32'h0000_0035, 32'(remote_transceiver_i.got));
		rd(`SP_DATA_OFS, 32'h0000_0000, "data_not_tx");
		rd(`SP_STAT_OFS, 32'h0000_0002, "tx_flag_held");
		wr(`SP_STAT_OFS, 32'h0000_0002);
		rd(`SP_STAT_OFS, 32'h0000_0000, "tx_flag_clear");
		chk("irq_clear", 32'h0000_0000, 32'(irq_o));
		// Every other timer clock source; bit time scales with the tick
		for (int i = 0; i < 5; i++)
		begin
			tmr.src = srcs[i];
			wr(`SP_TMR_OFS, {28'h000_0000, tmr});
			remote_transceiver_i.bit_clks = 16 * mult[i];
			tx_frame(9'(8'h81 + i), "tx_rate");
			wr(`SP_STAT_OFS, 32'h0000_0002);
		end
		tmr.src = serial_port_pkg::SRC_CORE;
		wr(`SP_TMR_OFS, {28'h000_0000, tmr});
		remote_transceiver_i.bit_clks = 16;
		wr(`SP_MASK_OFS, 32'h0000_0001);
		// Receive at arbitrary phase to the transmit timer
		remote_transceiver_i.send(9'h03c, 8, 1'b1);
		wait_irq();
		rd(`SP_DATA_OFS, 32'h0000_003c, "rx_byte");
		rd(`SP_CTRL_OFS, 32'h0000_0055, "ctrl_rx8");
		remote_transceiver_i.send(9'h0c3, 8, 1'b1);
		rd(`SP_DATA_OFS, 32'h0000_003c, "rx_overrun_kept");
		wr(`SP_STAT_OFS, 32'h0000_0001);
		rd(`SP_STAT_OFS, 32'h0000_0000, "rx_flag_clear");
		// Read the first byte while the second shifts in
		remote_transceiver_i.send(9'h011, 8, 1'b1);
		fork
			remote_transceiver_i.send(9'h022, 8, 1'b1);
		join_none
		repeat (48) @(posedge clk_i);
		rd(`SP_DATA_OFS, 32'h0000_0011, "rx_first_buffered");
		wr(`SP_STAT_OFS, 32'h0000_0001);
		wait fork;
		rd(`SP_DATA_OFS, 32'h0000_0022, "rx_second");
		wr(`SP_STAT_OFS, 32'h0000_0001);
		// Multidrop check in 8-bit mode: low stop bit drops the byte
		wr(`SP_CTRL_OFS, 32'h0000_0030);
		remote_transceiver_i.send(9'h044, 8, 1'b0);
		rd(`SP_STAT_OFS, 32'h0000_0000, "mce_stop_low");
		// 9-bit mode with multidrop: ninth bit 0 dropped, 1 loaded
		wr(`SP_CTRL_OFS, 32'h0000_00b0);
		remote_transceiver_i.send(9'h066, 9, 1'b1);
		rd(`SP_STAT_OFS, 32'h0000_0000, "mce_ninth_low");
		remote_transceiver_i.send(9'h177, 9, 1'b1);
		rd(`SP_DATA_OFS, 32'h0000_0077, "rx9_byte");
		rd(`SP_CTRL_OFS, 32'h0000_00f5, "ctrl_rx9");
		wr(`SP_STAT_OFS, 32'h0000_0001);
		// 9-bit transmit carries the ninth bit from control
		wr(`SP_CTRL_OFS, 32'h0000_0098);
		remote_transceiver_i.rx_bits = 9;
		wr(`SP_MASK_OFS, 32'h0000_0002);
		tx_frame(9'h1a5, "tx9_frame");
		// Masked flag stays set but raises no interrupt
		wr(`SP_MASK_OFS, 32'h0000_0000);
		rd(`SP_STAT_OFS, 32'h0000_0002, "flag_masked");
		chk("irq_masked", 32'h0000_0000, 32'(irq_o));
		report_and_stop();
	end
endmodule // async_serial_port_timer_baud_tb
